// [src/uart_rx_recovery_wakeup.sv]
// receive half of an asynchronous serial port with avalon-mm registers
// assumes rxd is asynchronous; stop_mode and wait_mode come from sys_clk
// logic; flags are cleared by reading status, then reading data
//
// What this block does
// - sixteen sample phases per received bit
// - start phases 8-10 high set noise only
// - stop majority low frames; disagreement flags noise
// - break character sets framing error
// - framing error rises with receive-full
// - falling edges after a one, outside phases 8-10, resync phase
// - stop sampled at phase ten of bit
// - standby suppresses all receiver interrupts
// - wake bit: one address mark, zero idle
// - address mark clears standby, sets full
// - idle wakeup sets neither idle nor full
// - idle type: count after stop or start
// - immediate idle wake tolerated
// - transfer sets full, interrupt if enabled
// - ten or eleven high bits set idle
// - overrun keeps old character, drops new
// - noise in any bit raises error interrupt if enabled
// - framing error gated by its enable
// - parity mismatch sets parity error flag
// - wait mode keeps running, interrupts wake
// - stop mode freezes state, no wakeup
//
// The register addresses and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "uart_rx_map.svh"

module uart_rx_recovery_wakeup
    import uart_rx_pkg::*;
#(
    parameter int BAUD_W = 16
) (
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output var  logic [31:0] readdata,
    output logic             waitrequest,
    input  wire logic        rxd,
    input  wire logic        wait_mode,
    input  wire logic        stop_mode,
    output logic             rx_irq,
    output logic             err_irq,
    output logic             cpu_wake
);

    // ==========================================================
    // elaboration check
    if (BAUD_W < 4 || BAUD_W > 16) begin : g_bad_width
        $error("BAUD_W must lie between 4 and 16");
    end

    // ==========================================================
    // registers
    rx_ctrl_t          ctrl;
    rx_flags_t         flags;
    logic              rx_standby_bit;
    logic [BAUD_W-1:0] baud;
    logic [8:0]        data_buf;
    logic              stat_seen;
    logic              ack;
    logic              rx_m;
    logic              rx_s;
    logic [BAUD_W-1:0] div_cnt;
    rx_state_t         state;
    logic [4:0]        phase;
    logic [3:0]        bit_idx;
    logic [2:0]        hist;
    logic [1:0]        smp;
    logic [8:0]        shift;
    logic              par_acc;
    logic              noise_acc;
    logic              last_bit;
    logic              prev_s;
    logic [7:0]        idle_cnt;
    logic              idle_armed;

    // ==========================================================
    // bus decode
    wire req       = read | write;
    wire accept    = req & ack;
    wire sel_c1    = (address == `UR_OFF_CTRL1);
    wire sel_c2    = (address == `UR_OFF_CTRL2);
    wire sel_c3    = (address == `UR_OFF_CTRL3);
    wire sel_s1    = (address == `UR_OFF_STAT1);
    wire sel_dat   = (address == `UR_OFF_DATA);
    wire sel_bd    = (address == `UR_OFF_BAUD);
    wire wr_c1     = accept & write & sel_c1;
    wire wr_c2     = accept & write & sel_c2;
    wire wr_c3     = accept & write & sel_c3;
    wire wr_bd     = accept & write & sel_bd;
    wire rd_s1     = accept & read & sel_s1;
    wire rd_dat    = accept & read & sel_dat;
    wire flag_clr  = rd_dat & stat_seen;
    // one wait state so read data is registered
    assign waitrequest = req & ~ack;

    wire [7:0] c1_val = {1'b0, ctrl.ensci, 1'b0, ctrl.nine,
                         ctrl.wake_addr, ctrl.idle_count_type_bit, ctrl.pen, ctrl.pty};
    wire [7:0] c2_val = {2'b00, ctrl.rie, ctrl.idle_irq_enable, 1'b0, ctrl.re,
                         rx_standby_bit, 1'b0};
    wire [7:0] c3_val = {data_buf[8], 3'b000, ctrl.overrun_irq_enable, ctrl.noise_irq_enable,
                         ctrl.framing_irq_enable, ctrl.parity_irq_enable};
    wire [7:0] s1_val = {2'b00, flags};
    wire [31:0] rd_mux =
        sel_c1  ? {24'h000000, c1_val} :
        sel_c2  ? {24'h000000, c2_val} :
        sel_c3  ? {24'h000000, c3_val} :
        sel_s1  ? {24'h000000, s1_val} :
        sel_dat ? {24'h000000, data_buf[7:0]} :
        sel_bd  ? {{(32-BAUD_W){1'b0}}, baud} : 32'h00000000;

    // ==========================================================
    // oversampling tick
    // stop mode freezes the receive state; the divider count clears
    wire run     = ~stop_mode & ctrl.ensci & ctrl.re;
    wire rt_tick = run & (div_cnt == baud);

    // ==========================================================
    // recovery decode
    wire [3:0] data_bits = ctrl.nine ? `UR_DATA_BITS9 : `UR_DATA_BITS8;
    wire [3:0] stop_idx  = data_bits + 4'h1;
    // only the two early samples of each trio are kept; the third is live
    wire       smp_ph    = ((state == ST_START)
                           & ((phase == `UR_PH_S1) | (phase == `UR_PH_S2)))
                         | ((state == ST_BITS)
                           & ((phase == `UR_PH_D1) | (phase == `UR_PH_D2)));
    wire       maj       = (smp[1] & smp[0]) | (smp[1] & rx_s)
                         | (smp[0] & rx_s);
    wire       disagree  = ~((smp[1] == smp[0]) & (smp[0] == rx_s));
    wire       at_s3     = rt_tick & (state == ST_START)
                         & (phase == `UR_PH_S3);
    wire [1:0] st_ones   = {1'b0, smp[1]} + {1'b0, smp[0]}
                         + {1'b0, rx_s};
    wire       st_ok     = (st_ones < 2'h2);
    wire       at_d3     = rt_tick & (state == ST_BITS)
                         & (phase == `UR_PH_D3);
    wire       is_start  = (bit_idx == 4'h0);
    wire       is_stop   = (bit_idx == stop_idx);
    wire       at_stop   = at_d3 & is_stop;
    wire       fall      = prev_s & ~rx_s;
    // resync on a valid falling edge after a one
    wire       resync    = rt_tick & (state == ST_BITS) & fall
                         & last_bit & ~is_start
                         & ((phase < `UR_PH_D1) | (phase > `UR_PH_D3));
    wire       bit_end   = rt_tick & (state == ST_BITS) & ~is_stop
                         & ((phase == `UR_PH_LAST)
                           | (resync & (phase > `UR_PH_D3)));
    wire       hunt_hit  = rt_tick & (state == ST_HUNT) & ~rx_s
                         & (&hist);

    // completed character, stop bit still being decided
    wire [8:0] char9     = ctrl.nine ? shift : {shift[8], shift[8:1]};
    wire       msb       = ctrl.nine ? shift[8] : shift[8];
    // stop majority low is a framing error
    wire       frame_err = ~maj;
    wire       noise_all = noise_acc | disagree;
    // parity over data and parity bit
    wire       par_err   = ctrl.pen & (par_acc != ctrl.pty);
    // address mark ends standby and is delivered
    wire       addr_wake = at_stop & rx_standby_bit & ctrl.wake_addr & msb;
    wire       deliver   = at_stop & (~rx_standby_bit | addr_wake);
    // second character while full is lost
    wire       overrun   = deliver & flags.full;
    wire       load      = deliver & ~flags.full;

    // ==========================================================
    // idle detection
    wire [7:0] idle_thr  = ctrl.nine ? `UR_IDLE_RT11 : `UR_IDLE_RT10;
    // idle type picks where counting may begin
    wire       idle_hold = ctrl.idle_count_type_bit ? (state != ST_HUNT)
                                     : (state == ST_START);
    wire       idle_lvl  = (idle_cnt == idle_thr);
    wire       idle_hit  = rt_tick & ~idle_hold & rx_s & ~idle_lvl
                         & (idle_cnt == idle_thr - 8'h01);
    // an already idle line wakes at once
    wire       idle_wake = rx_standby_bit & ~ctrl.wake_addr & idle_lvl & ~stop_mode;
    // idle flag after ten or eleven high bits
    wire       idle_set  = idle_hit & idle_armed & ~rx_standby_bit;

    // ==========================================================
    // interrupts
    // receive-full and idle requests
    wire rx_req  = (flags.full & ctrl.rie) | (flags.idle & ctrl.idle_irq_enable);
    wire err_req = (flags.ovr & ctrl.overrun_irq_enable) | (flags.noise & ctrl.noise_irq_enable)
                 | (flags.frame & ctrl.framing_irq_enable)
                 | (flags.parity & ctrl.parity_irq_enable);
    assign rx_irq   = rx_req & ~rx_standby_bit;
    assign err_irq  = err_req & ~rx_standby_bit;
    // wait mode wakeup; none in stop mode
    assign cpu_wake = (rx_irq | err_irq) & wait_mode & ~stop_mode;

    // ==========================================================
    // bus side
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ack      <= 1'b0;
            readdata <= 32'h00000000;
        end else begin
            ack      <= req & ~ack;
            readdata <= (req & ~ack) ? rd_mux : readdata;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl <= '0;
            baud <= BAUD_W'(`UR_BAUD_RST);
        end else begin
            if (wr_c1) begin
                ctrl.ensci     <= writedata[`UR_C1_ENSCI];
                ctrl.nine      <= writedata[`UR_C1_M];
                ctrl.wake_addr <= writedata[`UR_C1_WAKE];
                ctrl.idle_count_type_bit      <= writedata[`UR_C1_IDLE_COUNT_TYPE_BIT];
                ctrl.pen       <= writedata[`UR_C1_PEN];
                ctrl.pty       <= writedata[`UR_C1_PTY];
            end
            if (wr_c2) begin
                ctrl.rie  <= writedata[`UR_C2_RIE];
                ctrl.idle_irq_enable <= writedata[`UR_C2_IDLE_IRQ_ENABLE];
                ctrl.re   <= writedata[`UR_C2_RE];
            end
            if (wr_c3) begin
                ctrl.overrun_irq_enable <= writedata[`UR_C3_OVERRUN_IRQ_ENABLE];
                ctrl.noise_irq_enable <= writedata[`UR_C3_NOISE_IRQ_ENABLE];
                ctrl.framing_irq_enable <= writedata[`UR_C3_FRAMING_IRQ_ENABLE];
                ctrl.parity_irq_enable <= writedata[`UR_C3_PARITY_IRQ_ENABLE];
            end
            if (wr_bd) begin
                baud <= writedata[BAUD_W-1:0];
            end
        end
    end

    // standby bit: software write wins over a wake in the same cycle
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_standby_bit <= 1'b0;
        end else if (wr_c2) begin
            rx_standby_bit <= writedata[`UR_C2_RWU];
        end else if (addr_wake | idle_wake) begin
            rx_standby_bit <= 1'b0;
        end
    end

    // ==========================================================
    // flags: a set in the clearing cycle wins
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            flags     <= '0;
            stat_seen <= 1'b0;
        end else begin
            stat_seen    <= rd_s1 | (stat_seen & ~rd_dat);
            flags.full   <= load | (flags.full & ~flag_clr);
            flags.frame  <= (load & frame_err) | (flags.frame & ~flag_clr);
            flags.noise  <= (load & noise_all) | (flags.noise & ~flag_clr);
            flags.parity <= (load & par_err) | (flags.parity & ~flag_clr);
            flags.ovr    <= overrun | (flags.ovr & ~flag_clr);
            flags.idle   <= idle_set | (flags.idle & ~flag_clr);
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            data_buf <= 9'h000;
        end else if (load) begin
            data_buf <= char9;
        end
    end

    // ==========================================================
    // pin synchroniser and divider
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_m    <= 1'b1;
            rx_s    <= 1'b1;
            div_cnt <= '0;
        end else begin
            rx_m    <= rxd;
            rx_s    <= rx_m;
            div_cnt <= (~run | rt_tick) ? '0 : div_cnt + 1'b1;
        end
    end

    // ==========================================================
    // sampling and shifting
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            hist   <= 3'b000;
            smp    <= 2'b00;
            prev_s <= 1'b1;
        end else if (rt_tick) begin
            hist   <= {hist[1:0], rx_s};
            smp    <= smp_ph ? {smp[0], rx_s} : smp;
            prev_s <= rx_s;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            shift     <= 9'h000;
            par_acc   <= 1'b0;
            noise_acc <= 1'b0;
            last_bit  <= 1'b1;
        end else if (hunt_hit) begin
            par_acc   <= 1'b0;
            noise_acc <= 1'b0;
            last_bit  <= 1'b0;
        end else if (at_s3) begin
            noise_acc <= ~st_ok ? 1'b0 : (st_ones != 2'h0);
        end else if (at_d3 & is_start) begin
            // late start samples high are noise
            noise_acc <= noise_acc | smp[1] | smp[0] | rx_s;
        end else if (at_d3 & ~is_stop) begin
            shift     <= {maj, shift[8:1]};
            par_acc   <= par_acc ^ maj;
            noise_acc <= noise_acc | disagree;
            last_bit  <= maj;
        end
    end

    // ==========================================================
    // receive sequence
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state   <= ST_HUNT;
            phase   <= `UR_PH_FIRST;
            bit_idx <= 4'h0;
        end else if (~run) begin
            // receiver off or frozen: hold or abandon
            state <= stop_mode ? state : ST_HUNT;
        end else if (hunt_hit) begin
            state   <= ST_START;
            phase   <= `UR_PH_FIRST;
            bit_idx <= 4'h0;
        end else if (at_s3 & ~st_ok) begin
            state <= ST_HUNT;
        end else if (at_s3) begin
            state <= ST_BITS;
            phase <= phase + 5'h01;
        end else if (at_stop) begin
            // done at phase ten of stop bit
            // a break simply fails the stop test
            state <= ST_HUNT;
        end else if (bit_end) begin
            phase   <= `UR_PH_FIRST;
            bit_idx <= bit_idx + 4'h1;
        end else if (resync) begin
            phase <= `UR_PH_FIRST;
        end else if (rt_tick & (state != ST_HUNT)) begin
            phase <= phase + 5'h01;
        end
    end

    // ==========================================================
    // idle counter
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            idle_cnt   <= 8'h00;
            idle_armed <= 1'b0;
        end else begin
            if (rt_tick) begin
                if (~rx_s | idle_hold) begin
                    idle_cnt <= 8'h00;
                end else if (~idle_lvl) begin
                    idle_cnt <= idle_cnt + 8'h01;
                end
            end
            // one idle flag per quiet period after traffic
            idle_armed <= at_stop | (idle_armed & ~idle_hit);
        end
    end

endmodule : uart_rx_recovery_wakeup

`default_nettype wire

// [src/uart_rx_map.svh]
// register offsets, field positions, reset values and timing counts
// assumes byte addressing on a 32-bit avalon-mm slave port
`ifndef UART_RX_MAP_SVH
`define UART_RX_MAP_SVH

// ==========================================================
// register byte offsets
`define UR_OFF_CTRL1   8'h00
`define UR_OFF_CTRL2   8'h04
`define UR_OFF_CTRL3   8'h08
`define UR_OFF_STAT1   8'h0c
`define UR_OFF_DATA    8'h10
`define UR_OFF_BAUD    8'h14

// ==========================================================
// serial_control_one fields
`define UR_C1_ENSCI    6
`define UR_C1_M        4
`define UR_C1_WAKE     3
`define UR_C1_IDLE_COUNT_TYPE_BIT     2
`define UR_C1_PEN      1
`define UR_C1_PTY      0
// serial_control_two fields
`define UR_C2_RIE      5
`define UR_C2_IDLE_IRQ_ENABLE     4
`define UR_C2_RE       2
`define UR_C2_RWU      1
// serial_control_three fields
`define UR_C3_R8       7
`define UR_C3_OVERRUN_IRQ_ENABLE     3
`define UR_C3_NOISE_IRQ_ENABLE     2
`define UR_C3_FRAMING_IRQ_ENABLE     1
`define UR_C3_PARITY_IRQ_ENABLE     0
// serial_status_one fields
`define UR_S1_FULL     5
`define UR_S1_IDLE     4
`define UR_S1_OVR      3
`define UR_S1_NOISE    2
`define UR_S1_FRAME    1
`define UR_S1_PARITY   0

// ==========================================================
// reset values and timing
`define UR_BAUD_RST    16'h0043
`define UR_PH_FIRST    5'h01
`define UR_PH_S1       5'h03
`define UR_PH_S2       5'h05
`define UR_PH_S3       5'h07
`define UR_PH_D1       5'h08
`define UR_PH_D2       5'h09
`define UR_PH_D3       5'h0a
`define UR_PH_LAST     5'h10
`define UR_DATA_BITS8  4'h8
`define UR_DATA_BITS9  4'h9
`define UR_IDLE_RT10   8'ha0
`define UR_IDLE_RT11   8'hb0

`endif

// [src/uart_rx_pkg.sv]
// types shared by the receive block
// assumes uart_rx_map.svh holds every number
package uart_rx_pkg;

    typedef enum logic [1:0] {
        ST_HUNT  = 2'b00,
        ST_START = 2'b01,
        ST_BITS  = 2'b10
    } rx_state_t;

    typedef struct packed {
        logic full;
        logic idle;
        logic ovr;
        logic noise;
        logic frame;
        logic parity;
    } rx_flags_t;

    typedef struct packed {
        logic ensci;
        logic nine;
        logic wake_addr;
        logic idle_count_type_bit;
        logic pen;
        logic pty;
        logic rie;
        logic idle_irq_enable;
        logic re;
        logic overrun_irq_enable;
        logic noise_irq_enable;
        logic framing_irq_enable;
        logic parity_irq_enable;
    } rx_ctrl_t;

endpackage : uart_rx_pkg

// [test/uart_tx_model.sv]
// remote serial transmitter driving the receive line
// assumes one rt tick per sys_clk cycle (baud divisor 0)
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// frame driver
module uart_tx_model #(
    parameter int BIT_CYC = 16
) (
    input  wire logic sys_clk,
    output var  logic rxd
);
    // bit length in sys_clk cycles; the bench may stretch it
    int bit_len = BIT_CYC;
    // line rests at mark level between frames
    initial rxd = 1'b1;

    // g inverts one cycle of the frame, to plant noise
    task automatic send(input logic [8:0] d, input int nb,
                        input logic stop, input int g);
        int   b;
        logic v;
        for (int j = 0; j < (nb + 2) * bit_len; j++) begin
            b = j / bit_len;
            v = (b == 0) ? 1'b0 : (b <= nb) ? d[b - 1] : stop;
            @(posedge sys_clk);
            rxd <= v ^ (j == g);
        end
        @(posedge sys_clk);
        rxd <= 1'b1;
    endtask : send
endmodule : uart_tx_model

`default_nettype wire

// [test/uart_rx_checker.sv]
// port-level assertions for the receive block
// assumes one clock, sys_clk, and reset arst_n
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// checker
module uart_rx_checker (
    input wire logic        sys_clk,
    input wire logic        arst_n,
    input wire logic [7:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic        rxd,
    input wire logic        wait_mode,
    input wire logic        stop_mode,
    input wire logic        rx_irq,
    input wire logic        err_irq,
    input wire logic        cpu_wake
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sequence req_open;
        (read || write) && !$past(read || write);
    endsequence
    sequence req_wait;
        (read || write) && waitrequest;
    endsequence

    wait_first_a: assert property (req_open |-> waitrequest)
        else $error("request answered without a wait");
    wait_once_a: assert property (req_wait |=> !waitrequest)
        else $error("request waited more than one cycle");
    ack_after_a: assert property ((read || write) && !waitrequest
        |-> $past(waitrequest)) else $error("answer without wait");
    rdata_hold_a: assert property (!read && !write |=> $stable(readdata))
        else $error("read data moved with no request");
    wake_map_a: assert property (
        cpu_wake == ((rx_irq || err_irq) && wait_mode && !stop_mode))
        else $error("wake request wrong");
    stop_hold_a: assert property (stop_mode && !read && !write
        |=> $stable(rx_irq) && $stable(err_irq))
        else $error("interrupt moved while stopped");
    // flags only clear through software access
    rx_fall_a: assert property ($fell(rx_irq) |-> $past(read || write))
        else $error("receive interrupt fell alone");
    err_fall_a: assert property ($fell(err_irq) |-> $past(read || write))
        else $error("error interrupt fell alone");
endmodule : uart_rx_checker

bind uart_rx_recovery_wakeup uart_rx_checker u_uart_rx_checker (
    .sys_clk(sys_clk), .arst_n(arst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .rxd(rxd), .wait_mode(wait_mode),
    .stop_mode(stop_mode), .rx_irq(rx_irq), .err_irq(err_irq),
    .cpu_wake(cpu_wake));

`default_nettype wire

// [test/test_uart_rx_recovery_wakeup.sv]
// self-checking bench for the receive block
// assumes uart_tx_model on rxd and baud divisor 0 (16 cycles a bit)
`timescale 1ns/10ps
`default_nettype none
`include "uart_rx_map.svh"

// ==========================================================
// bench
module test_uart_rx_recovery_wakeup import uart_rx_pkg::*;;
    localparam logic [31:0] FULL = 32'h1 << `UR_S1_FULL,
        IDLE = 32'h1 << `UR_S1_IDLE, OVR = 32'h1 << `UR_S1_OVR,
        NOISE = 32'h1 << `UR_S1_NOISE, FRAME = 32'h1 << `UR_S1_FRAME,
        PAR = 32'h1 << `UR_S1_PARITY, C1 = 32'h44, NINE = 32'h10,
        WAKE = 32'h08, PEN = 32'h02, RIE = 32'h20, IDLE_IRQ_ENABLE = 32'h10,
        RE = 32'h04, SBY = 32'h02;
    logic        sys_clk = 1'b0;
    logic        arst_n, read, write, wait_mode, stop_mode;
    logic        rxd, waitrequest, rx_irq, err_irq, cpu_wake;
    logic [7:0]  address;
    logic [31:0] writedata, readdata, rd;
    logic [2:0]  snap;
    int          n_fail, check_count, cyc;
    int          gl[3] = '{8, 57, 154};

    uart_rx_recovery_wakeup u_uart_rx_recovery_wakeup (
        .sys_clk(sys_clk), .arst_n(arst_n), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .rxd(rxd),
        .wait_mode(wait_mode), .stop_mode(stop_mode), .rx_irq(rx_irq),
        .err_irq(err_irq), .cpu_wake(cpu_wake));
    uart_tx_model u_uart_tx_model (.sys_clk(sys_clk), .rxd(rxd));

    always #4 sys_clk = ~sys_clk;

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tmo;
        n_fail++;
        $display("mismatch at %0t: wait ran out", $time);
        report_and_stop();
    endtask : tmo

    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge sys_clk);
        address <= a;
        read <= !w;
        write <= w;
        writedata <= wd;
        do begin
            @(posedge sys_clk);
            n++;
            if (n > 50) tmo();
        end while (waitrequest !== 1'b0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 32'h0);
        check(rd, exp);
    endtask : rd_chk

    task automatic take(input logic [31:0] st, input logic [31:0] dt);
        rd_chk(`UR_OFF_STAT1, st);
        rd_chk(`UR_OFF_DATA, dt);
    endtask : take

    task automatic wait_sig(input logic which);
        cyc = 0;
        do begin
            @(negedge sys_clk);
            cyc++;
        end while ((which ? err_irq : rx_irq) !== 1'b1 && cyc < 400);
        snap = {rx_irq, err_irq, cpu_wake};
        if (cyc >= 400) tmo();
    endtask : wait_sig

    // frame is sent in parallel; the wait counts cycles to the interrupt
    task automatic xfer(input logic [8:0] d, input int nb, input logic stop,
                        input int g, input logic which);
        fork
            u_uart_tx_model.send(d, nb, stop, g);
        join_none
        wait_sig(which);
        repeat (4) @(posedge sys_clk);
    endtask : xfer

    initial begin
        {n_fail, check_count} = '0;
        {arst_n, read, write, wait_mode, stop_mode} = '0;
        address = 8'h00;
        writedata = 32'h0;
        repeat (4) @(posedge sys_clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 7; i++)
            rd_chk(8'(4 * i), (i == 5) ? 32'(`UR_BAUD_RST) : 32'h0); // reset
        bus(8'h18, 1'b1, 32'hff);
        rd_chk(8'h18, 32'h0);
        bus(`UR_OFF_BAUD, 1'b1, 32'h0);
        bus(`UR_OFF_CTRL3, 1'b1, 32'h0f);
        bus(`UR_OFF_CTRL1, 1'b1, C1);
        bus(`UR_OFF_CTRL2, 1'b1, RIE | RE);
        xfer(9'h0a5, 8, 1'b1, -1, 1'b0);
        check(32'(cyc >= 157 && cyc <= 161), 32'h1); // 8-bit length
        check(32'(snap[1]), 32'h0); // clean char
        take(FULL, 32'ha5); // full set
        u_uart_tx_model.bit_len = 17;
        xfer(9'h055, 8, 1'b1, -1, 1'b0);
        take(FULL, 32'h55); // slow sender realigned
        u_uart_tx_model.bit_len = 16;
        foreach (gl[i]) begin
            xfer(9'h03c, 8, 1'b1, gl[i], 1'b0);
            check(32'(snap[1]), 32'h1); // error request
            take(FULL | NOISE, 32'h3c); // noise
        end
        // break: no stop bit at all
        xfer(9'h000, 8, 1'b0, -1, 1'b1);
        check(32'(snap[2:1]), 32'h3); // same cycle
        take(FULL | FRAME, 32'h0); // break frames
        bus(`UR_OFF_CTRL1, 1'b1, C1 | PEN);
        xfer(9'h001, 8, 1'b1, -1, 1'b0);
        take(FULL | PAR, 32'h01); // odd count
        xfer(9'h081, 8, 1'b1, -1, 1'b0);
        take(FULL, 32'h81); // even count
        bus(`UR_OFF_CTRL1, 1'b1, C1);
        xfer(9'h011, 8, 1'b1, -1, 1'b0);
        xfer(9'h022, 8, 1'b1, -1, 1'b1);
        take(FULL | OVR, 32'h11); // old char kept
        bus(`UR_OFF_CTRL1, 1'b1, C1 | NINE | WAKE);
        bus(`UR_OFF_CTRL2, 1'b1, RIE | RE | SBY);
        fork
            u_uart_tx_model.send(9'h055, 9, 1'b1, -1);
        join_none
        repeat (200) @(negedge sys_clk);
        check(32'(rx_irq), 32'h0); // standby quiet
        rd_chk(`UR_OFF_STAT1, 32'h0); // no flags
        xfer(9'h155, 9, 1'b1, -1, 1'b0);
        check(32'(cyc >= 173 && cyc <= 177), 32'h1); // 9-bit length
        rd_chk(`UR_OFF_CTRL2, RIE | RE); // standby cleared
        rd_chk(`UR_OFF_CTRL3, 32'h8f); // mark bit
        take(FULL, 32'h55); // full set
        bus(`UR_OFF_CTRL1, 1'b1, C1);
        bus(`UR_OFF_CTRL2, 1'b1, RIE | IDLE_IRQ_ENABLE | RE);
        xfer(9'h00f, 8, 1'b1, -1, 1'b0);
        take(FULL, 32'h0f); // full set
        wait_sig(1'b0);
        take(IDLE, 32'h0f); // idle line
        bus(`UR_OFF_CTRL2, 1'b1, RIE | IDLE_IRQ_ENABLE | RE | SBY);
        rd_chk(`UR_OFF_CTRL2, RIE | IDLE_IRQ_ENABLE | RE); // wakes at once
        rd_chk(`UR_OFF_STAT1, 32'h0); // no idle or full
        bus(`UR_OFF_CTRL2, 1'b1, RIE | RE);
        @(posedge sys_clk) wait_mode <= 1'b1;
        xfer(9'h066, 8, 1'b1, -1, 1'b0);
        check(32'(snap[0]), 32'h1); // wakes cpu
        take(FULL, 32'h66); // still receiving
        @(posedge sys_clk) stop_mode <= 1'b1;
        // frame sent while stopped is lost on purpose
        fork
            u_uart_tx_model.send(9'h077, 8, 1'b1, -1);
        join_none
        repeat (200) @(negedge sys_clk);
        check(32'(rx_irq), 32'h0); // halted
        @(posedge sys_clk) stop_mode <= 1'b0;
        rd_chk(`UR_OFF_CTRL2, RIE | RE); // state kept
        rd_chk(`UR_OFF_STAT1, 32'h0); // nothing taken
        xfer(9'h012, 8, 1'b1, -1, 1'b0);
        take(FULL, 32'h12); // resumes
        report_and_stop();
    end
endmodule : test_uart_rx_recovery_wakeup

`default_nettype wire
